//--- hw/kmc_defs.svh
// Constants of the keypad mode controller: key positions, register map, fields, resets, timing
`ifndef KMC_DEFS_SVH
`define KMC_DEFS_SVH

`define KMC_KEY_VIEW        0
`define KMC_KEY_PARAM       1
`define KMC_KEY_RW          2
`define KMC_KEY_FWD         3
`define KMC_KEY_REV         4
`define KMC_KEY_STOP        5
`define KMC_KEY_UP          6
`define KMC_KEY_DOWN        7

`define KMC_ADDR_CTRL       4'h0
`define KMC_ADDR_PFREQ      4'h1
`define KMC_ADDR_LOLIM      4'h2
`define KMC_ADDR_STATUS     4'h3
`define KMC_ADDR_DISP       4'h4
`define KMC_ADDR_PMEM_BIT   3

`define KMC_CTRL_SRC_LSB    0
`define KMC_CTRL_V1_LSB     4
`define KMC_CTRL_V2_LSB     6
`define KMC_CTRL_POT_BIT    8

`define KMC_SRC_PANEL       4'h3
`define KMC_SRC_PANEL_AUTO  4'h8

`define KMC_CTRL_RST        9'h000
`define KMC_PFREQ_RST       16'h0000
`define KMC_LOLIM_RST       16'h0000
`define KMC_PMEM_RST        16'h0000

`define KMC_DEBOUNCE_MS     5
`define KMC_CLK_KHZ         100000
`define KMC_DEBOUNCE_CYC    (`KMC_DEBOUNCE_MS * `KMC_CLK_KHZ)

`endif

//--- hw/kmc_pkg.sv
// Types of the keypad mode controller
`default_nettype none
package kmc_pkg;

   typedef enum logic [1:0] {
      KMC_DRIVE_PANEL,
      KMC_MONITOR_VIEW,
      KMC_PARAM_EDIT,
      KMC_ALARM_VIEW
   } kmc_mode_t;

   typedef logic [15:0] kmc_word_t;

endpackage

`default_nettype wire

//--- hw/kmc_key_if.sv
// Key press strobes passed from the debouncer to the mode logic and editor
`timescale 1ns/1ps
`default_nettype none

interface kmc_key_if;
   logic [7:0] press;

   modport src (output press);
   modport snk (input press);
endinterface

`default_nettype wire

//--- hw/kmc_key_debounce.sv
// Key synchroniser and debouncer producing one-cycle press strobes
`timescale 1ns/1ps
`default_nettype none
`include "kmc_defs.svh"

module kmc_key_debounce #(
   parameter int unsigned TICK_CYCLES = `KMC_DEBOUNCE_CYC
)(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] key_in,
   kmc_key_if.src          keys
);

   logic [7:0]  s1_reg;
   logic [7:0]  s2_reg;
   logic [7:0]  smp_reg;
   logic [7:0]  smp_next;
   logic [7:0]  stab_reg;
   logic [7:0]  stab_next;
   logic [7:0]  press_reg;
   logic [7:0]  press_next;
   logic [19:0] cnt_reg;
   logic [19:0] cnt_next;
   logic        tick;

   // Two equal samples one tick apart are needed, so contact bounce never makes two strobes
   always_comb
   begin
      tick = (cnt_reg == 20'(TICK_CYCLES - 1));
      cnt_next = tick ? 20'h00000 : cnt_reg + 20'h00001;
      smp_next = tick ? s2_reg : smp_reg;
      stab_next = stab_reg;
      if (tick)
         stab_next = (~(s2_reg ^ smp_reg) & s2_reg) | ((s2_reg ^ smp_reg) & stab_reg);
      press_next = stab_next & ~stab_reg; // RQ19
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg    <= 8'h00;
         s2_reg    <= 8'h00;
         smp_reg   <= 8'h00;
         stab_reg  <= 8'h00;
         press_reg <= 8'h00;
         cnt_reg   <= 20'h00000;
      end
      else
      begin
         s1_reg    <= key_in;
         s2_reg    <= s1_reg;
         smp_reg   <= smp_next;
         stab_reg  <= stab_next;
         press_reg <= press_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign keys.press = press_reg;

endmodule

`default_nettype wire

//--- hw/kmc_freq_edit.sv
// Panel set-frequency editor: four decimal digits, a cursor and the lower limit clamp
`timescale 1ns/1ps
`default_nettype none
`include "kmc_defs.svh"

module kmc_freq_edit (
   input  wire logic        clk,
   input  wire logic        rst_n,
   kmc_key_if.snk           keys,
   input  wire logic        load,
   input  wire logic        active,
   input  wire logic [15:0] base_freq,
   input  wire logic [15:0] low_lim,
   output logic      [15:0] value,
   output logic      [1:0]  cursor,
   output logic             cursor_on,
   output logic             changed
);

   logic [15:0] value_reg;
   logic [15:0] value_next;
   logic [1:0]  cur_reg;
   logic [1:0]  cur_next;
   logic        on_reg;
   logic        on_next;
   logic        chg_reg;
   logic        chg_next;

   // Packed decimal digits compare correctly as plain unsigned numbers
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
      clamp = (v < lim) ? lim : v;
   endfunction

   function automatic logic [15:0] digit_step(input logic [15:0] v, input logic [1:0] pos,
                                              input logic up);
      logic [3:0] d;
      d = v[{pos, 2'b00} +: 4];
      if (up && d < 4'h9)
         d = d + 4'h1;
      else if (!up && d > 4'h0)
         d = d - 4'h1;
      digit_step = v;
      digit_step[{pos, 2'b00} +: 4] = d;
   endfunction

   always_comb
   begin
      value_next = value_reg;
      cur_next = cur_reg;
      on_next = on_reg;
      chg_next = 1'b0;
      if (load)
      begin
         value_next = clamp(base_freq, low_lim); // RQ7
         cur_next = 2'h0;
         on_next = 1'b0;
      end
      else if (active)
      begin
         if (keys.press[`KMC_KEY_STOP])
            cur_next = cur_reg + 2'h1; // RQ10
         if (keys.press[`KMC_KEY_UP] || keys.press[`KMC_KEY_DOWN])
         begin
            if (!on_reg)
               on_next = 1'b1; // RQ9
            else
            begin
               value_next = clamp(digit_step(value_reg, cur_reg, keys.press[`KMC_KEY_UP]),
                                  low_lim); // RQ8
               chg_next = (value_next != value_reg);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         value_reg <= `KMC_PFREQ_RST;
         cur_reg   <= 2'h0;
         on_reg    <= 1'b0;
         chg_reg   <= 1'b0;
      end
      else
      begin
         value_reg <= value_next;
         cur_reg   <= cur_next;
         on_reg    <= on_next;
         chg_reg   <= chg_next;
      end
   end

   assign value = value_reg;
   assign cursor = cur_reg;
   assign cursor_on = on_reg;
   assign changed = chg_reg;

endmodule

`default_nettype wire

//--- hw/kmc_top.sv
// Keypad mode controller: modes, run commands, lamps, display and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "kmc_defs.svh"

// What this block does
// RQ1 - Four digits, four lamps, eight keys, four modes
// RQ2 - View key toggles drive and monitor mode
// RQ3 - Drive mode keeps frequency and current lamps dark
// RQ4 - Forward, reverse and stop keys work in both
// RQ5 - Frequency editing only with source 3 or 8
// RQ6 - Read/write key enters blinking set-frequency submode
// RQ7 - Edited frequency never below the lower limit
// RQ8 - Up and down keys change the set frequency
// RQ9 - First up/down shows cursor, later ones edit
// RQ10 - Stop shifts cursor while editing frequency
// RQ11 - View key leaves submode back to drive mode
// RQ12 - Source 8 writes edited frequency back automatically
// RQ13 - Frequency view shows output frequency or selection
// RQ14 - Current view shows output current or selection
// RQ15 - Up/down in monitor picks view and lamp
// RQ16 - Panel potentiometer behaves as analog input three
// RQ17 - Read/write key stores edited parameter value
// RQ18 - Stop in alarm view triggers drive reset
// RQ19 - Keys debounced into single-cycle press strobes
// RQ20 - Reset starts in drive mode, lamps dark
module kmc_top #(
   parameter int unsigned DEBOUNCE_CYCLES = `KMC_DEBOUNCE_CYC
)(
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  KEYS,
   input  wire logic [15:0] OUT_FREQ,
   input  wire logic [15:0] OUT_CURR,
   input  wire logic [11:0] AI3_LEVEL,
   input  wire logic [11:0] POT_LEVEL,
   input  wire logic [15:0] ALARM_CODE,
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic      [15:0] DISP_DATA,
   output logic             DISP_BLINK,
   output logic      [3:0]  DISP_CURSOR,
   output logic      [3:0]  LAMPS,
   output logic             RUN_FWD,
   output logic             RUN_REV,
   output logic             DRIVE_RESET
);

   kmc_key_if keys ();

   kmc_pkg::kmc_mode_t mode_reg;
   kmc_pkg::kmc_mode_t mode_next;
   logic               setf_reg;
   logic               setf_next;
   logic               view_reg;
   logic               view_next;
   logic               fwd_reg;
   logic               fwd_next;
   logic               rev_reg;
   logic               rev_next;
   logic               drst_reg;
   logic               drst_next;
   logic [2:0]         pidx_reg;
   logic [2:0]         pidx_next;
   logic               prd_reg;
   logic               prd_next;
   logic [15:0]        pval_reg;
   logic [15:0]        pval_next;
   logic [1:0]         pcur_reg;
   logic [1:0]         pcur_next;
   logic               wait_reg;
   logic               wait_next;
   logic [31:0]        rdata_reg;
   logic [31:0]        rdata_next;
   logic [8:0]         ctrl_reg;
   logic [8:0]         ctrl_next;
   logic [15:0]        pfreq_reg;
   logic [15:0]        pfreq_next;
   logic [15:0]        lolim_reg;
   logic [15:0]        lolim_next;
   logic [15:0]        pmem_reg [8];
   logic [15:0]        pmem_next [8];
   logic [15:0]        disp_reg;
   logic [15:0]        disp_next;
   logic               blink_reg;
   logic               blink_next;
   logic [3:0]         curs_reg;
   logic [3:0]         curs_next;
   logic [3:0]         lamp_reg;
   logic [3:0]         lamp_next;
   logic [7:0]         kp;
   logic [3:0]         src;
   logic               fs_ok;
   logic [11:0]        ain3;
   logic               bus_wr;
   logic               ed_load;
   logic               pf_wr;
   logic               mem_wr;
   logic [15:0]        ed_value;
   logic [1:0]         ed_cursor;
   logic               ed_cursor_on;
   logic               ed_changed;

   kmc_key_debounce #(
      .TICK_CYCLES (DEBOUNCE_CYCLES)
   ) u_debounce (
      .clk    (CLOCK),
      .rst_n  (RST_N),
      .key_in (KEYS),
      .keys   (keys)
   );

   kmc_freq_edit u_edit (
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .keys      (keys),
      .load      (ed_load),
      .active    (setf_reg),
      .base_freq (pfreq_reg),
      .low_lim   (lolim_reg),
      .value     (ed_value),
      .cursor    (ed_cursor),
      .cursor_on (ed_cursor_on),
      .changed   (ed_changed)
   );

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      be_merge = old;
      for (int i = 0; i < 4; i++)
         if (be[i])
            be_merge[8*i +: 8] = wd[8*i +: 8];
   endfunction

   function automatic logic [15:0] view_pick(input logic [1:0] sel, input logic [15:0] dflt,
                                             input logic [11:0] a3, input logic [15:0] pf);
      case (sel)
         2'h1:    view_pick = {4'h0, a3};
         2'h2:    view_pick = pf;
         default: view_pick = dflt;
      endcase
   endfunction

   assign kp = keys.press;
   assign src = ctrl_reg[`KMC_CTRL_SRC_LSB +: 4];
   assign fs_ok = (src == `KMC_SRC_PANEL) || (src == `KMC_SRC_PANEL_AUTO); // RQ5
   assign ain3 = ctrl_reg[`KMC_CTRL_POT_BIT] ? POT_LEVEL : AI3_LEVEL; // RQ16

   // Panel mode logic; the key strobes are one cycle wide, so each press acts once
   always_comb
   begin
      mode_next = mode_reg;
      setf_next = setf_reg;
      view_next = view_reg;
      fwd_next = fwd_reg;
      rev_next = rev_reg;
      drst_next = 1'b0;
      pidx_next = pidx_reg;
      prd_next = prd_reg;
      pval_next = pval_reg;
      pcur_next = pcur_reg;
      ed_load = 1'b0;
      pf_wr = 1'b0;
      mem_wr = 1'b0;
      case (mode_reg) // RQ1
         kmc_pkg::KMC_DRIVE_PANEL, kmc_pkg::KMC_MONITOR_VIEW:
         begin
            if (kp[`KMC_KEY_FWD])
            begin
               fwd_next = 1'b1; // RQ4
               rev_next = 1'b0;
            end
            else if (kp[`KMC_KEY_REV])
            begin
               fwd_next = 1'b0; // RQ4
               rev_next = 1'b1;
            end
            if (kp[`KMC_KEY_STOP])
            begin
               fwd_next = 1'b0; // RQ4
               rev_next = 1'b0;
            end
            if (kp[`KMC_KEY_PARAM])
            begin
               mode_next = kmc_pkg::KMC_PARAM_EDIT;
               setf_next = 1'b0;
               prd_next = 1'b0;
            end
            else if (kp[`KMC_KEY_VIEW])
            begin
               if (setf_reg)
                  setf_next = 1'b0; // RQ11
               else if (mode_reg == kmc_pkg::KMC_DRIVE_PANEL)
                  mode_next = kmc_pkg::KMC_MONITOR_VIEW; // RQ2
               else
                  mode_next = kmc_pkg::KMC_DRIVE_PANEL; // RQ2
            end
            else if (mode_reg == kmc_pkg::KMC_DRIVE_PANEL)
            begin
               if (!fs_ok)
                  setf_next = 1'b0; // RQ5
               else if (kp[`KMC_KEY_RW] && !setf_reg)
               begin
                  setf_next = 1'b1; // RQ6
                  ed_load = 1'b1;
               end
               else if (kp[`KMC_KEY_RW])
                  pf_wr = 1'b1;
               if (setf_reg && ed_changed && src == `KMC_SRC_PANEL_AUTO)
                  pf_wr = 1'b1; // RQ12
            end
            else if (kp[`KMC_KEY_UP] || kp[`KMC_KEY_DOWN])
               view_next = ~view_reg; // RQ15
         end
         kmc_pkg::KMC_PARAM_EDIT:
         begin
            if (kp[`KMC_KEY_VIEW])
               mode_next = kmc_pkg::KMC_DRIVE_PANEL;
            else if (kp[`KMC_KEY_PARAM])
               mode_next = kmc_pkg::KMC_ALARM_VIEW;
            else if (kp[`KMC_KEY_RW])
            begin
               mem_wr = prd_reg; // RQ17
               prd_next = ~prd_reg;
               pval_next = pmem_reg[pidx_reg];
               pcur_next = 2'h0;
            end
            else if (kp[`KMC_KEY_STOP])
               pcur_next = pcur_reg + 2'h1;
            else if (kp[`KMC_KEY_UP] || kp[`KMC_KEY_DOWN])
            begin
               if (prd_reg && kp[`KMC_KEY_UP])
                  pval_next = pval_reg + (16'h0001 << {pcur_reg, 2'b00});
               else if (prd_reg)
                  pval_next = pval_reg - (16'h0001 << {pcur_reg, 2'b00});
               else if (kp[`KMC_KEY_UP])
                  pidx_next = pidx_reg + 3'h1;
               else
                  pidx_next = pidx_reg - 3'h1;
            end
         end
         kmc_pkg::KMC_ALARM_VIEW:
         begin
            if (kp[`KMC_KEY_VIEW])
               mode_next = kmc_pkg::KMC_DRIVE_PANEL;
            else if (kp[`KMC_KEY_PARAM])
            begin
               mode_next = kmc_pkg::KMC_PARAM_EDIT;
               prd_next = 1'b0;
            end
            else if (kp[`KMC_KEY_STOP])
               drst_next = 1'b1; // RQ18
         end
         default:
            mode_next = kmc_pkg::KMC_DRIVE_PANEL;
      endcase
   end

   // Display and lamps follow the state in the same edge as the mode change
   always_comb
   begin
      disp_next = OUT_FREQ;
      blink_next = 1'b0;
      curs_next = 4'h0;
      lamp_next = {rev_next, fwd_next, 2'b00}; // RQ3
      case (mode_next)
         kmc_pkg::KMC_DRIVE_PANEL:
         begin
            if (setf_next)
            begin
               disp_next = ed_load ? ((pfreq_reg < lolim_reg) ? lolim_reg : pfreq_reg) // RQ7
                                   : ed_value; // RQ6
               blink_next = 1'b1;
               // Cursor flag of an earlier session is cleared only by this load
               if (ed_cursor_on && !ed_load)
                  curs_next = 4'h1 << ed_cursor; // RQ9
            end
         end
         kmc_pkg::KMC_MONITOR_VIEW:
         begin
            lamp_next[1:0] = view_next ? 2'b10 : 2'b01; // RQ15
            if (view_next)
               disp_next = view_pick(ctrl_reg[`KMC_CTRL_V2_LSB +: 2], OUT_CURR, ain3,
                                     pfreq_reg); // RQ14
            else
               disp_next = view_pick(ctrl_reg[`KMC_CTRL_V1_LSB +: 2], OUT_FREQ, ain3,
                                     pfreq_reg); // RQ13
         end
         kmc_pkg::KMC_PARAM_EDIT:
         begin
            lamp_next[1:0] = 2'b11;
            disp_next = prd_next ? pval_next : {13'h0000, pidx_next};
            if (prd_next)
               curs_next = 4'h1 << pcur_next;
         end
         default:
            disp_next = ALARM_CODE;
      endcase
   end

   // Avalon slave: waitrequest drops one cycle after the request, for exactly one cycle
   always_comb
   begin
      wait_next = ~((AVS_READ || AVS_WRITE) && wait_reg);
      bus_wr = AVS_WRITE && !wait_reg;
      rdata_next = rdata_reg;
      if (AVS_READ && wait_reg)
      begin
         rdata_next = 32'h00000000;
         if (AVS_ADDRESS[`KMC_ADDR_PMEM_BIT])
            rdata_next = {16'h0000, pmem_reg[AVS_ADDRESS[2:0]]};
         else
            case (AVS_ADDRESS)
               `KMC_ADDR_CTRL:   rdata_next = {23'h000000, ctrl_reg};
               `KMC_ADDR_PFREQ:  rdata_next = {16'h0000, pfreq_reg};
               `KMC_ADDR_LOLIM:  rdata_next = {16'h0000, lolim_reg};
               `KMC_ADDR_STATUS: rdata_next = {4'h0, ain3, 11'h000, rev_reg, fwd_reg,
                                               setf_reg, mode_reg};
               `KMC_ADDR_DISP:   rdata_next = {16'h0000, disp_reg};
               default:          rdata_next = 32'h00000000;
            endcase
      end
      ctrl_next = ctrl_reg;
      pfreq_next = pfreq_reg;
      lolim_next = lolim_reg;
      if (bus_wr && AVS_ADDRESS == `KMC_ADDR_CTRL)
         ctrl_next = 9'(be_merge({23'h000000, ctrl_reg}, AVS_WRITEDATA, AVS_BYTEENABLE));
      if (bus_wr && AVS_ADDRESS == `KMC_ADDR_PFREQ)
         pfreq_next = 16'(be_merge({16'h0000, pfreq_reg}, AVS_WRITEDATA, AVS_BYTEENABLE));
      if (bus_wr && AVS_ADDRESS == `KMC_ADDR_LOLIM)
         lolim_next = 16'(be_merge({16'h0000, lolim_reg}, AVS_WRITEDATA, AVS_BYTEENABLE));
      if (pf_wr)
         pfreq_next = ed_value; // RQ12
      pmem_next = pmem_reg;
      if (bus_wr && AVS_ADDRESS[`KMC_ADDR_PMEM_BIT])
         pmem_next[AVS_ADDRESS[2:0]] = 16'(be_merge({16'h0000, pmem_reg[AVS_ADDRESS[2:0]]},
                                                    AVS_WRITEDATA, AVS_BYTEENABLE));
      if (mem_wr)
         pmem_next[pidx_reg] = pval_reg; // RQ17
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mode_reg  <= kmc_pkg::KMC_DRIVE_PANEL; // RQ20
         setf_reg  <= 1'b0;
         view_reg  <= 1'b0;
         fwd_reg   <= 1'b0;
         rev_reg   <= 1'b0;
         drst_reg  <= 1'b0;
         pidx_reg  <= 3'h0;
         prd_reg   <= 1'b0;
         pval_reg  <= `KMC_PMEM_RST;
         pcur_reg  <= 2'h0;
         disp_reg  <= 16'h0000;
         blink_reg <= 1'b0;
         curs_reg  <= 4'h0;
         lamp_reg  <= 4'h0; // RQ20
      end
      else
      begin
         mode_reg  <= mode_next;
         setf_reg  <= setf_next;
         view_reg  <= view_next;
         fwd_reg   <= fwd_next;
         rev_reg   <= rev_next;
         drst_reg  <= drst_next;
         pidx_reg  <= pidx_next;
         prd_reg   <= prd_next;
         pval_reg  <= pval_next;
         pcur_reg  <= pcur_next;
         disp_reg  <= disp_next;
         blink_reg <= blink_next;
         curs_reg  <= curs_next;
         lamp_reg  <= lamp_next;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h00000000;
         ctrl_reg  <= `KMC_CTRL_RST;
         pfreq_reg <= `KMC_PFREQ_RST;
         lolim_reg <= `KMC_LOLIM_RST;
         pmem_reg  <= '{default: `KMC_PMEM_RST};
      end
      else
      begin
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
         ctrl_reg  <= ctrl_next;
         pfreq_reg <= pfreq_next;
         lolim_reg <= lolim_next;
         pmem_reg  <= pmem_next;
      end
   end

   assign AVS_READDATA = rdata_reg;
   assign AVS_WAITREQUEST = wait_reg;
   assign DISP_DATA = disp_reg;
   assign DISP_BLINK = blink_reg;
   assign DISP_CURSOR = curs_reg;
   assign LAMPS = lamp_reg;
   assign RUN_FWD = fwd_reg;
   assign RUN_REV = rev_reg;
   assign DRIVE_RESET = drst_reg;

endmodule

`default_nettype wire

//--- tb/kmc_top_sva.sv
// Port-level checks for the keypad mode controller
`timescale 1ns/1ps
`default_nettype none

module kmc_top_sva #(
   parameter int unsigned DEBOUNCE_CYCLES = 4
)(
   input wire logic       CLOCK,
   input wire logic       RST_N,
   input wire logic [7:0] KEYS,
   input wire logic       AVS_READ,
   input wire logic       AVS_WRITE,
   input wire logic       AVS_WAITREQUEST,
   input wire logic       DISP_BLINK,
   input wire logic [3:0] DISP_CURSOR,
   input wire logic [3:0] LAMPS,
   input wire logic       RUN_FWD,
   input wire logic       RUN_REV,
   input wire logic       DRIVE_RESET
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   sequence bus_take;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence
   sequence one_wait;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence

   bus_answer_a: assert property (bus_take |=> one_wait)
      else $error("bus answer not a single wait-low cycle");
   run_excl_a: assert property (!(RUN_FWD && RUN_REV))
      else $error("both run commands high");
   run_lamps_a: assert property (LAMPS[3:2] == {RUN_REV, RUN_FWD})
      else $error("run lamps differ from run commands");
   blink_dark_a: assert property (DISP_BLINK |-> LAMPS[1:0] == 2'b00)
      else $error("view lamp lit in set-frequency submode");
   reset_pulse_a: assert property (DRIVE_RESET |=> !DRIVE_RESET)
      else $error("drive reset pulse longer than one cycle");
   cursor_hot_a: assert property ($onehot0(DISP_CURSOR))
      else $error("cursor shows more than one digit");
   // Debounce means no key can act within four cycles of its rise
   key_settle_a: assert property ($rose(|KEYS) |=> $stable(LAMPS) [*4])
      else $error("lamps changed before debounce settled");
   reset_state_a: assert property ($rose(RST_N) |->
      LAMPS == 4'h0 && !DISP_BLINK && DISP_CURSOR == 4'h0)
      else $error("outputs not idle after reset");
endmodule

bind kmc_top kmc_top_sva #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_kmc_top_sva (.*);

`default_nettype wire

//--- tb/kmc_keypad_model.sv
// Operator keypad model pressing one key at a time
`timescale 1ns/1ps
`default_nettype none

module kmc_keypad_model (
   input  wire logic       clk,
   output logic      [7:0] keys
);
   initial keys = 8'h00;

   // Hold and release both outlast twice the debounce tick of 4 cycles
   task automatic press(input int k);
      @(posedge clk);
      keys <= 8'h01 << k;
      repeat (12) @(posedge clk);
      keys <= 8'h00;
      repeat (14) @(posedge clk);
   endtask
endmodule

`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the keypad mode controller
`timescale 1ns/1ps
`default_nettype none
`include "kmc_defs.svh"

module tb;
   logic        CLOCK = 1'b0, RST_N = 1'b0;
   logic [7:0]  KEYS;
   logic [15:0] OUT_FREQ = 16'h0450, OUT_CURR = 16'h0123, ALARM_CODE = 16'h0E07;
   logic [11:0] AI3_LEVEL = 12'h0AB, POT_LEVEL = 12'h3C5;
   logic [3:0]  AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
   logic        AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA;
   logic        AVS_WAITREQUEST, DISP_BLINK, RUN_FWD, RUN_REV, DRIVE_RESET;
   logic [15:0] DISP_DATA;
   logic [3:0]  DISP_CURSOR, LAMPS;
   int          bad_count = 0, compares = 0, pulses = 0;

   kmc_top #(.DEBOUNCE_CYCLES(4)) u_kmc_top (.*);
   kmc_keypad_model u_pad (.clk(CLOCK), .keys(KEYS));

   always #5 CLOCK = ~CLOCK;
   always @(posedge CLOCK)
      if (DRIVE_RESET === 1'b1)
         pulses <= pulses + 1;

   task automatic close_out();
      $display("mismatches %0d compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waitrequest and read data are taken at the rising edge, before the slave updates them
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      q = 32'h00000000;
      @(posedge CLOCK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_BYTEENABLE <= be;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (AVS_WAITREQUEST !== 1'b0 && n < 40);
      if (AVS_WAITREQUEST !== 1'b0)
      begin
         bad_count++;
         $display("wrong value at %0t: bus answer timed out", $time);
         close_out();
      end
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      acc(1'b1, a, d, be, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(1'b0, a, 32'h0, 4'hF, q);
      chk(q, e);
   endtask

   initial
   begin
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'b1;
      rd(4'h3, {4'h0, AI3_LEVEL, 16'h0000});
      chk(LAMPS, 4'h0);
      wr(4'h0, 32'h1FF, 4'hF);
      rd(4'h0, 32'h1FF);
      wr(4'h0, 32'h0, 4'h1);
      rd(4'h0, 32'h100);
      wr(4'h5, 32'hFFFF, 4'hF);
      rd(4'h5, 32'h0);
      wr(4'h0, 32'h143, 4'hF);
      u_pad.press(`KMC_KEY_VIEW);
      chk({LAMPS, DISP_DATA}, {4'h1, OUT_FREQ});
      u_pad.press(`KMC_KEY_UP);
      chk({LAMPS, DISP_DATA}, {4'h2, 4'h0, POT_LEVEL});
      u_pad.press(`KMC_KEY_DOWN);
      chk(LAMPS, 4'h1);
      u_pad.press(`KMC_KEY_FWD);
      chk(RUN_FWD, 1'b1);
      u_pad.press(`KMC_KEY_STOP);
      chk(RUN_FWD, 1'b0);
      u_pad.press(`KMC_KEY_VIEW);
      chk(LAMPS, 4'h0);
      u_pad.press(`KMC_KEY_REV);
      chk(RUN_REV, 1'b1);
      u_pad.press(`KMC_KEY_STOP);
      wr(4'h2, 32'h120, 4'hF);
      wr(4'h1, 32'h100, 4'hF);
      u_pad.press(`KMC_KEY_RW);
      chk({DISP_BLINK, RUN_REV, DISP_DATA}, {2'b10, 16'h0120});
      u_pad.press(`KMC_KEY_UP);
      chk({DISP_CURSOR, DISP_DATA}, {4'h1, 16'h0120});
      u_pad.press(`KMC_KEY_UP);
      chk(DISP_DATA, 16'h0121);
      u_pad.press(`KMC_KEY_STOP);
      chk(DISP_CURSOR, 4'h2);
      u_pad.press(`KMC_KEY_DOWN);
      chk(DISP_DATA, 16'h0120);
      rd(4'h1, 32'h100);
      wr(4'h0, 32'h148, 4'hF);
      u_pad.press(`KMC_KEY_UP);
      rd(4'h1, 32'h130);
      u_pad.press(`KMC_KEY_VIEW);
      chk({DISP_BLINK, LAMPS}, 5'h00);
      wr(4'h0, 32'h0, 4'hF);
      u_pad.press(`KMC_KEY_RW);
      chk(DISP_BLINK, 1'b0);
      u_pad.press(`KMC_KEY_PARAM);
      chk(LAMPS, 4'h3);
      u_pad.press(`KMC_KEY_RW);
      u_pad.press(`KMC_KEY_UP);
      u_pad.press(`KMC_KEY_RW);
      rd(4'h8, 32'h1);
      u_pad.press(`KMC_KEY_PARAM);
      chk(DISP_DATA, ALARM_CODE);
      rd(4'h3, {4'h0, AI3_LEVEL, 16'h0003});
      u_pad.press(`KMC_KEY_STOP);
      chk(pulses, 32'h1);
      RST_N <= 1'b0;
      repeat (2) @(posedge CLOCK);
      RST_N <= 1'b1;
      rd(4'h3, {4'h0, AI3_LEVEL, 16'h0000});
      close_out();
   end
endmodule

`default_nettype wire
